// ### incl_spi_master.sv
module incl_spi_master (
    output logic      sck,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle: clock still; select rises once to clear the link logic
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        #1 cs_n = 1'b1;
    end
    // One framed transfer, zeros after the command
    task automatic xfer(input logic [7:0] cmd, input int n, output logic [19:0] rx);
        rx = '0;
        #1.3 cs_n = 1'b0;
        #128;
        for (int i = 0; i < n; i++) begin
            mosi = (i < 8) ? cmd[7 - i] : 1'b0;
            #32 sck = 1'b1; // half period of the bench link clock
            rx = {rx[18:0], miso};
            #32 sck = 1'b0;
        end
        #128 cs_n = 1'b1;
        mosi = ~mosi;
        #15000;
    endtask
endmodule

// ### incl_spi_pkg.sv
package incl_spi_pkg;
    // Command codes
    localparam logic [7:0] CMD_MEASURE     = 8'h00;
    localparam logic [7:0] CMD_TEMP_RW     = 8'h08;
    localparam logic [7:0] CMD_READ_STATUS = 8'h0a;
    localparam logic [7:0] CMD_NV_RELOAD   = 8'h0b;
    localparam logic [7:0] CMD_SELFTEST_X  = 8'h0e;
    localparam logic [7:0] CMD_SELFTEST_Y  = 8'h0f;
    localparam logic [7:0] CMD_READ_ACCEL_X = 8'h10;
    localparam logic [7:0] CMD_READ_ACCEL_Y = 8'h11;
    // Frame layout
    localparam int CMD_BITS   = 8;
    localparam int ACCEL_BITS = 11;
    localparam int TEMP_BITS  = 8;
    // Valid sample window and forced failure value
    localparam logic [10:0] ACCEL_MIN  = 11'h066;
    localparam logic [10:0] ACCEL_MAX  = 11'h799;
    localparam logic [10:0] ACCEL_FAIL = 11'h000;
    // Reset values
    localparam logic [10:0] ACCEL_RESET = 11'h400;
    localparam logic [7:0]  TEMP_RESET  = 8'h00;
    localparam logic [7:0]  STAT_RESET  = 8'h00;
    // Refresh interval
    localparam int CLK_MHZ       = 200;
    localparam int REFRESH_US    = 150;
    localparam int REFRESH_CYC   = REFRESH_US * CLK_MHZ;
    // Link phases
    typedef enum logic [1:0] {
        PH_CMD  = 2'b00,
        PH_RESP = 2'b01,
        PH_DEAD = 2'b10,
        PH_DONE = 2'b11
    } phase_t;
endpackage

// ### inclinometer_spi_slave.sv
// Summary of operation
// - A transfer spans exactly one low interval of chip select.
// - Commands and data travel most significant bit first in both directions.
// - Serial output bits change on falling serial clock edges.
// - Serial input bits are captured on rising serial clock edges.
// - First eight input bits after select form the command word.
// - Deselect stops shifting and clears bit counter and command register.
// - Invalid command: ignore further input, output stays high impedance.
// - First response bit driven on the falling edge after last command bit.
// - Response bits shift out while write data bits shift in.
// - Codes: measure 00, temperature 08, status 0a.
// - Codes: reload 0b, X self test 0e, Y self test 0f.
// - Codes: X acceleration 10, Y acceleration 11.
// - Measurement mode after reset; measure command ends any self test.
// - Temperature refreshes every 150 us, held while selected.
// - Temperature read leaves operation alone; written data is ignored.
// - Temperature command returns eight bits, most significant first.
// - Self test commands enable the channel charge pump until measure.
// - Acceleration registers reload every 150 us, held while selected.
// - Acceleration read returns eleven bits, most significant first.
// - Detected failure forces acceleration output below 102 counts.
module inclinometer_spi_slave (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        spi_sck,
    input  wire logic        chip_select_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso_o,
    output logic             spi_miso_oe,
    input  wire logic [10:0] accel_x_in,
    input  wire logic [10:0] accel_y_in,
    input  wire logic [7:0]  temp_in,
    input  wire logic [7:0]  status_in,
    input  wire logic        fail_in,
    output logic             selftest_x,
    output logic             selftest_y,
    output logic             nv_reload,
    output logic             selected
);
    import incl_spi_pkg::*;

    // ---------------- System clock domain ----------------
    logic [15:0] refresh_cnt;
    logic [10:0] accel_x;
    logic [10:0] accel_y;
    logic [7:0]  temp;
    logic [7:0]  status;
    logic [1:0]  cs_sync;
    logic [2:0]  cmd_tgl_sync;
    logic        refresh_due;
    logic        refresh_load;
    logic        link_idle;
    logic [10:0] next_accel_x;
    logic [10:0] next_accel_y;

    // Chip select level brought into the system domain
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_sync <= 2'b11;
        end else if (clk_en) begin
            cs_sync <= {cs_sync[0], chip_select_n};
        end
    end

    // Idle level after two flops; timer end point
    assign link_idle    = cs_sync[1];
    assign refresh_due  = (refresh_cnt == 16'(REFRESH_CYC - 1));
    assign refresh_load = link_idle && refresh_due;

    // Failure forces samples out of the valid window
    assign next_accel_x = fail_in ? ACCEL_FAIL : accel_x_in;
    assign next_accel_y = fail_in ? ACCEL_FAIL : accel_y_in;

    // Refresh timer, paused while selected
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            refresh_cnt <= '0;
        end else if (clk_en && link_idle) begin
            refresh_cnt <= refresh_due ? '0 : refresh_cnt + 16'h0001;
        end
    end

    // X sample register, reloaded only while deselected
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            accel_x <= ACCEL_RESET;
        end else if (clk_en && refresh_load) begin
            accel_x <= next_accel_x;
        end
    end

    // Y sample register, reloaded only while deselected
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            accel_y <= ACCEL_RESET;
        end else if (clk_en && refresh_load) begin
            accel_y <= next_accel_y;
        end
    end

    // Temperature register, reloaded only while deselected
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            temp <= TEMP_RESET;
        end else if (clk_en && refresh_load) begin
            temp <= temp_in;
        end
    end

    // Status register, reloaded with the others
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= STAT_RESET;
        end else if (clk_en && refresh_load) begin
            status <= status_in;
        end
    end

    // ---------------- Link clock domain ----------------
    phase_t      phase;
    logic [2:0]  bit_cnt;
    logic [6:0]  cmd_sr;
    logic [7:0]  cmd_word;
    logic        cmd_tgl;
    logic [10:0] resp_sr;
    logic [3:0]  resp_left;
    logic        miso_q;
    logic        drive_q;
    logic [7:0]  next_cmd;
    logic        cmd_valid;
    logic        cmd_read;
    logic        cmd_last;
    logic [10:0] load_val;
    logic [3:0]  load_len;
    logic        resp_start;
    logic [3:0]  next_resp_left;
    logic        is_measure;
    logic        is_temp_rw;
    logic        is_read_status;
    logic        is_nv_reload;
    logic        is_selftest_x;
    logic        is_selftest_y;
    logic        is_accel_x;
    logic        is_accel_y;

    // Word as it stands with the bit now on the input line
    assign next_cmd = {cmd_sr, spi_mosi};

    // One flag per known command code
    assign is_measure     = (next_cmd == CMD_MEASURE);
    assign is_temp_rw     = (next_cmd == CMD_TEMP_RW);
    assign is_read_status = (next_cmd == CMD_READ_STATUS);
    assign is_nv_reload   = (next_cmd == CMD_NV_RELOAD);
    assign is_selftest_x  = (next_cmd == CMD_SELFTEST_X);
    assign is_selftest_y  = (next_cmd == CMD_SELFTEST_Y);
    assign is_accel_x     = (next_cmd == CMD_READ_ACCEL_X);
    assign is_accel_y     = (next_cmd == CMD_READ_ACCEL_Y);

    // Whole command checks on the eighth rising edge
    assign cmd_valid = is_measure || is_temp_rw || is_read_status || is_nv_reload ||
                       is_selftest_x || is_selftest_y || is_accel_x || is_accel_y;
    assign cmd_read  = is_temp_rw || is_read_status || is_accel_x || is_accel_y;
    assign cmd_last  = (phase == PH_CMD) && (bit_cnt == 3'(CMD_BITS - 1));

    // Response word left aligned, chosen by the captured command word
    always_comb begin
        load_val = '0;
        load_len = 4'(TEMP_BITS);
        case (cmd_word)
            CMD_READ_ACCEL_X: begin
                load_val = accel_x;
                load_len = 4'(ACCEL_BITS);
            end
            CMD_READ_ACCEL_Y: begin
                load_val = accel_y;
                load_len = 4'(ACCEL_BITS);
            end
            CMD_TEMP_RW:      load_val = {temp, 3'b000};
            CMD_READ_STATUS:  load_val = {status, 3'b000};
            default:          load_val = '0;
        endcase
    end

    // ---------------- Link sampling side ----------------

    // Command bit counter, cleared by deselect
    always_ff @(posedge spi_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            bit_cnt <= '0;
        end else if (phase == PH_CMD) begin
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    // Command shifter, input ignored once the word is complete
    always_ff @(posedge spi_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            cmd_sr <= '0;
        end else if (phase == PH_CMD) begin
            cmd_sr <= next_cmd[6:0];
        end
    end

    // Transfer phase, decided by the whole command word
    always_ff @(posedge spi_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            phase <= PH_CMD;
        end else begin
            case (phase)
                PH_CMD: begin
                    if (bit_cnt == 3'(CMD_BITS - 1)) begin
                        if (!cmd_valid) begin
                            phase <= PH_DEAD;
                        end else if (cmd_read) begin
                            phase <= PH_RESP;
                        end else begin
                            phase <= PH_DONE;
                        end
                    end
                end
                PH_RESP: phase <= PH_RESP;   // Write data ignored
                PH_DEAD: phase <= PH_DEAD;   // No input accepted
                PH_DONE: phase <= PH_DONE;
                default: phase <= PH_DEAD;
            endcase
        end
    end

    // Command word held for the launch side and the system domain
    always_ff @(posedge spi_sck or negedge rst_b) begin
        if (!rst_b) begin
            cmd_word <= CMD_MEASURE;
            cmd_tgl  <= 1'b0;
        end else if (!chip_select_n && cmd_last && cmd_valid) begin
            cmd_word <= next_cmd;
            cmd_tgl  <= ~cmd_tgl;
        end
    end

    // ---------------- Link launch side ----------------

    // Response load and countdown steps
    assign resp_start     = (phase == PH_RESP) && !drive_q;
    assign next_resp_left = (resp_left == 4'h0) ? 4'h0 : resp_left - 4'h1;

    // Output enable: set on the first response edge, dropped after the last bit
    always_ff @(negedge spi_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            drive_q <= 1'b0;
        end else if (resp_start) begin
            drive_q <= 1'b1;
        end else if (drive_q) begin
            drive_q <= (resp_left != 4'h0);
        end
    end

    // Output bit, changed on falling serial clock and cleared by deselect
    always_ff @(negedge spi_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            miso_q <= 1'b0;
        end else if (resp_start) begin
            miso_q <= load_val[10];
        end else if (drive_q) begin
            miso_q <= resp_sr[10];
        end
    end

    // Response shifter, most significant bit leaves first
    always_ff @(negedge spi_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            resp_sr <= '0;
        end else if (resp_start) begin
            resp_sr <= {load_val[9:0], 1'b0};
        end else if (drive_q) begin
            resp_sr <= {resp_sr[9:0], 1'b0};
        end
    end

    // Bits still to send after the one on the line
    always_ff @(negedge spi_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            resp_left <= '0;
        end else if (resp_start) begin
            resp_left <= load_len - 4'h1;
        end else if (drive_q) begin
            resp_left <= next_resp_left;
        end
    end

    // Serial output pins follow the launch flip-flops directly
    assign spi_miso_o  = miso_q;
    assign spi_miso_oe = drive_q;

    // ---------------- Link to system crossing ----------------

    // Command event into system domain
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_tgl_sync <= '0;
        end else if (clk_en) begin
            cmd_tgl_sync <= {cmd_tgl_sync[1:0], cmd_tgl};
        end
    end

    logic        cmd_event;
    logic [7:0]  cmd_seen;
    logic        measure_seen;
    logic        stx_seen;
    logic        sty_seen;
    logic        reload_seen;
    // One pulse per toggle after two flops
    assign cmd_event = cmd_tgl_sync[2] ^ cmd_tgl_sync[1];
    // Word is stable long before the toggle arrives
    assign cmd_seen  = cmd_word;

    // Decoded command events in the system domain
    assign measure_seen = cmd_event && (cmd_seen == CMD_MEASURE);
    assign stx_seen     = cmd_event && (cmd_seen == CMD_SELFTEST_X);
    assign sty_seen     = cmd_event && (cmd_seen == CMD_SELFTEST_Y);
    assign reload_seen  = cmd_event && (cmd_seen == CMD_NV_RELOAD);

    // ---------------- Mode control ----------------

    // Selected flag from the synchronised select
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            selected <= 1'b0;
        end else if (clk_en) begin
            selected <= ~link_idle;
        end
    end

    // One cycle reload pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nv_reload <= 1'b0;
        end else if (clk_en) begin
            nv_reload <= reload_seen;
        end
    end

    // X charge pump enable, held until measure
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            selftest_x <= 1'b0;
        end else if (clk_en) begin
            if (measure_seen) begin
                selftest_x <= 1'b0;
            end else if (stx_seen) begin
                selftest_x <= 1'b1;
            end
        end
    end

    // Y charge pump enable, held until measure
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            selftest_y <= 1'b0;
        end else if (clk_en) begin
            if (measure_seen) begin
                selftest_y <= 1'b0;
            end else if (sty_seen) begin
                selftest_y <= 1'b1;
            end
        end
    end
endmodule

// ### inclinometer_spi_slave_properties.sv
module incl_spi_checker import incl_spi_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic spi_sck,
    input wire logic chip_select_n,
    input wire logic spi_mosi,
    input wire logic spi_miso_o,
    input wire logic spi_miso_oe,
    input wire logic selftest_x,
    input wire logic selftest_y,
    input wire logic nv_reload,
    input wire logic selected
);
    logic [4:0] bits;
    logic [7:0] cmd;
    // Command class decode
    wire rd8   = cmd == CMD_TEMP_RW || cmd == CMD_READ_STATUS;
    wire rd11  = cmd == CMD_READ_ACCEL_X || cmd == CMD_READ_ACCEL_Y;
    wire ctl   = cmd == CMD_MEASURE || cmd == CMD_NV_RELOAD;
    wire valid = rd8 || rd11 || ctl || cmd == CMD_SELFTEST_X || cmd == CMD_SELFTEST_Y;
    // Rising edges seen in this frame, command shift
    always_ff @(posedge spi_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            bits <= '0;
            cmd <= '0;
        end else begin
            if (bits != 5'h1f) bits <= bits + 5'h01;
            if (bits < 5'h08) cmd <= {cmd[6:0], spi_mosi};
        end
    end
    sequence s_read_start;
        bits == 5'h08 && (rd8 || rd11);
    endsequence
    sequence s_last_then_off;
        spi_miso_oe ##1 !spi_miso_oe;
    endsequence
    a_first_bit_drive: assert property (@(posedge spi_sck) disable iff (chip_select_n)
        s_read_start |-> spi_miso_oe) else $error("response not driven after command");
    a_cmd_phase_quiet: assert property (@(posedge spi_sck) disable iff (chip_select_n)
        bits < 5'h08 |-> !spi_miso_oe) else $error("output driven during command");
    a_invalid_silent: assert property (@(posedge spi_sck) disable iff (chip_select_n)
        bits >= 5'h08 && !valid |-> !spi_miso_oe) else $error("invalid command drove output");
    a_accel_length: assert property (@(posedge spi_sck) disable iff (chip_select_n)
        bits == 5'h12 && rd11 |-> s_last_then_off) else $error("accel length wrong");
    a_temp_length: assert property (@(posedge spi_sck) disable iff (chip_select_n)
        bits == 5'h0f && rd8 |-> s_last_then_off) else $error("byte read length wrong");
    a_falling_change: assert property (@(posedge clk) disable iff (!rst_b)
        spi_sck && $past(spi_sck) |-> $stable(spi_miso_o)) else $error("output moved, sck high");
    a_idle_hiz: assert property (@(posedge clk) disable iff (!rst_b)
        chip_select_n && $past(chip_select_n) |-> !spi_miso_oe) else $error("driven while idle");
    a_reload_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        nv_reload |=> !nv_reload) else $error("reload pulse too long");
    a_select_seen: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(chip_select_n) |-> ##[1:6] selected) else $error("select not seen");
    a_reset_mode: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> !selftest_x && !selftest_y) else $error("self test after reset");
endmodule

bind inclinometer_spi_slave incl_spi_checker chk_u (.clk(clk), .rst_b(rst_b),
    .spi_sck(spi_sck), .chip_select_n(chip_select_n), .spi_mosi(spi_mosi),
    .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .selftest_x(selftest_x),
    .selftest_y(selftest_y), .nv_reload(nv_reload), .selected(selected));

// ### inclinometer_spi_slave_tb.sv
module inclinometer_spi_slave_tb import incl_spi_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 0, rst_b = 0, clk_en = 1, fail_in = 0;
    logic [10:0] accel_x_in = 11'h5a3, accel_y_in = 11'h2b7;
    logic [7:0]  temp_in = 8'h9c, status_in = 8'h3a;
    logic        spi_sck, chip_select_n, spi_mosi;
    logic        spi_miso_o, spi_miso_oe, selftest_x, selftest_y, nv_reload, selected;
    logic [19:0] rx;
    int          fail_count = 0, total_checks = 0, pulses = 0;
    wire         miso = spi_miso_oe ? spi_miso_o : 1'bz;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (nv_reload) pulses++;
    incl_spi_master master_u (.sck(spi_sck), .cs_n(chip_select_n), .mosi(spi_mosi), .miso(miso));
    inclinometer_spi_slave dut_u (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .spi_sck(spi_sck),
        .chip_select_n(chip_select_n), .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o),
        .spi_miso_oe(spi_miso_oe), .accel_x_in(accel_x_in), .accel_y_in(accel_y_in),
        .temp_in(temp_in), .status_in(status_in), .fail_in(fail_in), .selftest_x(selftest_x),
        .selftest_y(selftest_y), .nv_reload(nv_reload), .selected(selected));
    // Compare with four-state equality
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Reads after a full refresh interval
    task automatic t_reads;
        cyc(REFRESH_CYC + 100);
        master_u.xfer(CMD_READ_ACCEL_X, 20, rx);
        chk("accel_x", {8'hzz, accel_x_in, 1'bz}, rx);
        master_u.xfer(CMD_READ_ACCEL_Y, 20, rx);
        chk("accel_y", {8'hzz, accel_y_in, 1'bz}, rx);
        master_u.xfer(CMD_TEMP_RW, 17, rx);
        chk("temp", {3'h0, 8'hzz, temp_in, 1'bz}, rx);
        master_u.xfer(CMD_READ_STATUS, 17, rx);
        chk("status", {3'h0, 8'hzz, status_in, 1'bz}, rx);
        master_u.xfer(8'h05, 20, rx);
        chk("invalid", 20'hzzzzz, rx);
        $display("reads done");
    endtask
    // Self test entry and exit, one channel at a time
    task automatic t_modes;
        logic [7:0] cmds [4];
        logic [1:0] exp [4];
        cmds = '{CMD_SELFTEST_X, CMD_MEASURE, CMD_SELFTEST_Y, CMD_MEASURE};
        exp = '{2'b10, 2'b00, 2'b01, 2'b00};
        chk("reset mode", 20'h0, {selftest_x, selftest_y});
        for (int i = 0; i < 4; i++) begin
            master_u.xfer(cmds[i], 8, rx);
            chk("selftest", exp[i], {selftest_x, selftest_y});
        end
        master_u.xfer(CMD_NV_RELOAD, 8, rx);
        chk("reload pulses", 20'h1, pulses);
        chk("selected idle", 20'h0, selected);
        $display("modes done");
    endtask
    // Failure forces out-of-range sample
    task automatic t_fail;
        fail_in = 1'b1;
        cyc(REFRESH_CYC + 100);
        master_u.xfer(CMD_READ_ACCEL_X, 20, rx);
        chk("fail accel", {8'hzz, ACCEL_FAIL, 1'bz}, rx);
        $display("fail done");
    endtask
    initial begin
        cyc(12);
        rst_b = 1'b1;
        t_modes();
        t_reads();
        t_fail();
        results();
    end
endmodule
